/* gpio_regs.svh */
// register offsets, field positions, reset values and widths for the gpio port block
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH
`define ADDR_W 6
`define OFF_DIR 6'h00
`define OFF_LAT 6'h01
`define OFF_PIN 6'h02
`define OFF_ODC 6'h03
`define OFF_APC 6'h04
`define OFF_CNEN 6'h05
`define OFF_CNPU 6'h06
`define OFF_MODULE_DISABLE_CTRL_8 6'h07
`define OFF_CNSTAT 6'h08
`define OFF_REMAP0 6'h10
`define DIR_RESET 16'hFFFF
`define APC_RESET 16'h0000
`define CCS_DIS_BIT 1
`define SEL_W 6
`endif

/* gpio_pkg.sv */
// types shared by the gpio port block
package gpio_pkg;
  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } pin_drive_s;
endpackage : gpio_pkg

/* remap_sel.sv */
// one peripheral input selector over the remappable pins
module remap_sel #(
  parameter int N_RP = 16
) (
  input wire logic [5:0] sel, // selected remappable pin number
  input wire logic [N_RP-1:0] rp_level, // remappable pin levels
  output logic y // routed level
);
  always_comb begin
    if (sel < 6'(N_RP)) begin
      y = rp_level[sel[$clog2(N_RP)-1:0]];
    end else begin
      y = 1'b0;
    end
  end
endmodule : remap_sel

/* gpio_port.sv */
// gpio port with peripheral sharing, open drain, analog config, change notify and input remap
// What this block does
// - active peripheral drive disables port driver
// - idle enabled peripheral lets port drive
// - port output never loops into peripheral
// - direction bit one input, zero output
// - reset sets all pins input
// - latch register reads and writes latch
// - port reads pins, writes go latch
// - unimplemented bits read zero everywhere
// - open-drain bit makes latch output open-drain; peripheral-driven pins ignore it
// - analog config resets zero, pins analog
// - analog pins read zero in port
// - enabled pin change raises interrupt, seen on the synced level
// - change enable bit gates each pin
// - pull-up bit enables weak pull-up
// - six-bit field picks remappable pin
// - remap covers up to sixteen pins
// - bit one disables constant current source
`include "gpio_regs.svh"
module gpio_port #(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF,
  parameter int N_RP = 16,
  parameter int N_RIN = 4
) (
  input wire logic clk, // 200 MHz clock
  input wire logic reset, // async reset, active high
  input wire logic [5:0] addr, // register index
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [15:0] rdata, // read data, cycle after rd
  input wire logic [15:0] pin_in, // pad input levels
  output logic [15:0] pin_out, // pad output value
  output logic [15:0] pin_oe, // pad output enable, high drives
  output logic [15:0] pullup_en, // weak pull-up enables
  input wire logic [15:0] periph_en, // peripheral enabled per pin
  input wire logic [15:0] periph_drive, // peripheral actively driving per pin
  input wire logic [15:0] periph_out, // peripheral output value per pin
  output logic [15:0] periph_in, // pin level seen by shared peripherals
  output logic [N_RIN-1:0] remap_in, // remapped peripheral inputs
  output logic change_irq, // change notification request
  output logic current_source_disable // constant current source off
);
  import gpio_pkg::*;
  initial begin
    // the selector indexes with clog2(N_RP) bits, so a single pin cannot be served
    if (N_RP < 2 || N_RP > 16) $error("N_RP must be 2..16");
    if (N_RIN < 1 || N_RIN > 16) $error("N_RIN must be 1..16");
  end
  bus_req_s req;
  pin_drive_s drv;
  logic [15:0] pin_direction_reg, output_latch_reg, open_drain_select_reg;
  logic [15:0] analog_pin_config_reg, change_irq_enable_reg, change_pullup_enable_reg;
  logic [15:0] module_disable_ctrl_8, change_of_state;
  logic [15:0] sync1, sync2, prev_lvl;
  logic [5:0] input_remap_select_reg [N_RIN];
  logic [15:0] pin_level_reg, next_rdata, cos_event;
  logic [N_RP-1:0] rp_level;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  // pads are asynchronous: two flops before any logic
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1 <= 16'h0000;
      sync2 <= 16'h0000;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_direction_reg <= `DIR_RESET & IMPL_MASK;
    end else if (req.wr && req.addr == `OFF_DIR) begin
      pin_direction_reg <= req.wdata & IMPL_MASK;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      output_latch_reg <= 16'h0000;
    end else if (req.wr && (req.addr == `OFF_LAT || req.addr == `OFF_PIN)) begin
      output_latch_reg <= req.wdata & IMPL_MASK;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      open_drain_select_reg <= 16'h0000;
      analog_pin_config_reg <= `APC_RESET;
      change_irq_enable_reg <= 16'h0000;
      change_pullup_enable_reg <= 16'h0000;
      module_disable_ctrl_8 <= 16'h0000;
    end else if (req.wr) begin
      case (req.addr)
        `OFF_ODC: open_drain_select_reg <= req.wdata & IMPL_MASK;
        `OFF_APC: analog_pin_config_reg <= req.wdata & IMPL_MASK;
        `OFF_CNEN: change_irq_enable_reg <= req.wdata & IMPL_MASK;
        `OFF_CNPU: change_pullup_enable_reg <= req.wdata & IMPL_MASK;
        `OFF_MODULE_DISABLE_CTRL_8: module_disable_ctrl_8 <= req.wdata & (16'h0001 << `CCS_DIS_BIT);
        default: ;
      endcase
    end
  end
  for (genvar g = 0; g < N_RIN; g++) begin : g_remap
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        input_remap_select_reg[g] <= 6'h3F;
      end else if (req.wr && req.addr == `OFF_REMAP0 + 6'(g)) begin
        input_remap_select_reg[g] <= req.wdata[`SEL_W-1:0];
      end
    end
    remap_sel #(.N_RP(N_RP)) u_sel (
      .sel(input_remap_select_reg[g]),
      .rp_level(rp_level),
      .y(remap_in[g])
    );
  end
  // analog pins read low; unimplemented pins read low
  // config bit one selects digital, so a cleared bit (analog) masks the pad
  assign pin_level_reg = sync2 & analog_pin_config_reg & IMPL_MASK;
  assign rp_level = pin_level_reg[N_RP-1:0];
  // a sleep-mode detector would be asynchronous; here changes are seen on the synced level
  assign cos_event = (sync2 ^ prev_lvl) & change_irq_enable_reg & IMPL_MASK;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_lvl <= 16'h0000;
      change_of_state <= 16'h0000;
    end else begin
      prev_lvl <= sync2;
      // set wins over a same-cycle write-one-to-clear
      if (req.wr && req.addr == `OFF_CNSTAT) begin
        change_of_state <= (change_of_state & ~req.wdata) | cos_event;
      end else begin
        change_of_state <= change_of_state | cos_event;
      end
    end
  end
  assign change_irq = |change_of_state;
  always_comb begin
    next_rdata = 16'h0000;
    case (req.addr)
      `OFF_DIR: next_rdata = pin_direction_reg;
      `OFF_LAT: next_rdata = output_latch_reg;
      `OFF_PIN: next_rdata = pin_level_reg;
      `OFF_ODC: next_rdata = open_drain_select_reg;
      `OFF_APC: next_rdata = analog_pin_config_reg;
      `OFF_CNEN: next_rdata = change_irq_enable_reg;
      `OFF_CNPU: next_rdata = change_pullup_enable_reg;
      `OFF_MODULE_DISABLE_CTRL_8: next_rdata = module_disable_ctrl_8;
      `OFF_CNSTAT: next_rdata = change_of_state;
      default: begin
        for (int i = 0; i < N_RIN; i++) begin
          if (req.addr == `OFF_REMAP0 + 6'(i)) next_rdata = {10'h000, input_remap_select_reg[i]};
        end
      end
    endcase
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 16'h0000;
    end else if (req.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 16'h0000;
    end
  end
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (periph_en[i] && periph_drive[i]) begin
        drv.out[i] = periph_out[i];
        drv.oe[i] = 1'b1;
      end else begin
        drv.out[i] = output_latch_reg[i];
        drv.oe[i] = ~pin_direction_reg[i];
        if (open_drain_select_reg[i] && output_latch_reg[i]) drv.oe[i] = 1'b0;
      end
      if (!IMPL_MASK[i]) drv.oe[i] = 1'b0;
    end
  end
  assign pin_out = drv.out;
  assign pin_oe = drv.oe;
  // peripherals see only the pad, never the port latch
  assign periph_in = sync2 & IMPL_MASK;
  assign pullup_en = change_pullup_enable_reg;
  assign current_source_disable = module_disable_ctrl_8[`CCS_DIS_BIT];
endmodule : gpio_port

/* gpio_port_properties.sv */
// checker on the gpio_port ports
`include "gpio_regs.svh"
module gpio_port_checker #(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF,
  parameter int N_RIN = 4
) (
  input wire logic clk, reset, wr, rd, change_irq, current_source_disable,
  input wire logic [5:0] addr,
  input wire logic [15:0] rdata, pin_in, pin_out, pin_oe, periph_en, periph_drive, periph_out, periph_in,
  input wire logic [N_RIN-1:0] remap_in
);
  logic [15:0] own;
  assign own = periph_en & periph_drive;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_periph_owns_oe: assert property ((own & IMPL_MASK & ~pin_oe) == 16'h0000)
    else $error("pin not driven for its peripheral");
  a_periph_owns_out: assert property (((pin_out ^ periph_out) & own) == 16'h0000)
    else $error("port value leaked onto a peripheral pin");
  // sampled while reset is high, so the default disable is switched off here
  a_reset_state: assert property (disable iff (1'b0) reset && own == 16'h0000 |->
    pin_oe == 16'h0000 && remap_in == '0) else $error("pins or remap active in reset");
  a_no_loop_through: assert property (!$past(reset) && !$past(reset, 2) |->
    periph_in == ($past(pin_in, 2) & IMPL_MASK)) else $error("peripheral input not from pad");
  a_ccs_readback: assert property (rd && addr == `OFF_MODULE_DISABLE_CTRL_8 |=>
    rdata == {14'h0000, current_source_disable, 1'b0}) else $error("module disable readback wrong");
  a_unimpl_quiet: assert property ((pin_oe & ~IMPL_MASK) == 16'h0000)
    else $error("unimplemented pin driven");
  a_irq_sticky: assert property (change_irq && !wr |=> change_irq)
    else $error("change request dropped without a write");
  a_irq_cause: assert property ($rose(change_irq) |->
    $past(periph_in) != $past(periph_in, 2) || $past(periph_in, 2) != $past(periph_in, 3))
    else $error("change request without pin change");
  c_periph_drive: cover property (|own);
  c_irq: cover property ($rose(change_irq));
  c_ccs_read: cover property (rd && addr == `OFF_MODULE_DISABLE_CTRL_8);
endmodule : gpio_port_checker
bind gpio_port gpio_port_checker #(.IMPL_MASK(IMPL_MASK), .N_RIN(N_RIN)) chk (.*);

/* pad_model.sv */
// pads and external drivers around the port
module pad_model (
  input wire logic [15:0] pin_out, pin_oe, pullup_en, ext_en, ext_val,
  output logic [15:0] pin_in
);
  // a released pad with no external driver and no pull-up shows the inverse of the port value, never a kind default
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pullup_en | ~pin_out));
endmodule : pad_model

/* gpio_port_bench.sv */
// self-checking bench for gpio_port
`include "gpio_regs.svh"
module gpio_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, wr, rd, change_irq, current_source_disable;
  logic [5:0] addr;
  logic [15:0] wdata, rdata, pin_in, pin_out, pin_oe, pullup_en, periph_en, periph_drive, periph_out;
  logic [15:0] periph_in, ext_en, ext_val;
  logic [3:0] remap_in;
  int fail_count = 0, tests_run = 0, cycles = 0;
  gpio_port #(.IMPL_MASK(16'h7FFF)) dut (.*);
  pad_model pads (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : pause
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd_chk
  task automatic t_port;
    rd_chk(`OFF_DIR, 16'h7FFF);
    rd_chk(`OFF_APC, 16'h0000);
    rd_chk(6'h3E, 16'h0000);
    wr_reg(`OFF_DIR, 16'hFF00);
    wr_reg(`OFF_PIN, 16'h00A5);
    rd_chk(`OFF_LAT, 16'h00A5);
    check(pin_oe, 16'h00FF);
    rd_chk(`OFF_PIN, 16'h0000);
    wr_reg(`OFF_APC, 16'hFFFF);
    rd_chk(`OFF_PIN, 16'h5AA5);
    wr_reg(`OFF_LAT, 16'hFFFF);
    rd_chk(`OFF_LAT, 16'h7FFF);
    wr_reg(`OFF_LAT, 16'h00A5);
    wr_reg(`OFF_ODC, 16'h00FF);
    pause(1);
    check(pin_oe, 16'h005A);
    wr_reg(`OFF_ODC, 16'h0000);
    $display("port test done");
  endtask : t_port
  task automatic t_periph;
    @(posedge clk);
    periph_en <= 16'h0003;
    periph_drive <= 16'h0001;
    pause(1);
    check(pin_oe & 16'h0003, 16'h0003);
    check(pin_out & 16'h0003, 16'h0000);
    rd_chk(`OFF_PIN, 16'h5AA4);
    check(periph_in, 16'h5AA4);
    @(posedge clk);
    periph_en <= 16'h0000;
    periph_drive <= 16'h0000;
    $display("peripheral test done");
  endtask : t_periph
  task automatic t_notify;
    wr_reg(`OFF_CNEN, 16'h1000);
    ext_val <= 16'h7A00;
    pause(5);
    check(16'(change_irq), 16'h0000);
    @(posedge clk);
    ext_val <= 16'h6A00;
    pause(5);
    check(16'(change_irq), 16'h0001);
    wr_reg(`OFF_CNSTAT, 16'hFFFF);
    pause(1);
    check(16'(change_irq), 16'h0000);
    wr_reg(`OFF_CNPU, 16'h0300);
    pause(1);
    check(pullup_en, 16'h0300);
    $display("notify test done");
  endtask : t_notify
  task automatic t_remap_ccs;
    wr_reg(`OFF_REMAP0, 16'h000D);
    pause(1);
    check(16'(remap_in[0]), 16'h0001);
    wr_reg(`OFF_REMAP0, 16'h0010);
    pause(1);
    check(16'(remap_in[0]), 16'h0000);
    wr_reg(`OFF_MODULE_DISABLE_CTRL_8, 16'hFFFF);
    rd_chk(`OFF_MODULE_DISABLE_CTRL_8, 16'h0002);
    check(16'(current_source_disable), 16'h0001);
    $display("remap and current source test done");
  endtask : t_remap_ccs
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    {reset, wr, rd, addr, wdata} = {1'b1, 24'h000000};
    {periph_en, periph_drive, periph_out} = '0;
    ext_en = 16'hFF00;
    ext_val = 16'h5A00;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_port();
    t_periph();
    t_notify();
    t_remap_ccs();
    end_of_test();
  end
endmodule : gpio_port_bench
